/* File: design/atfc_top.sv */
// Task-file control: status mirror, device control, command acceptance
// What this block does
// - Alternate status returns primary status bits
// - Alternate status read keeps interrupt pending
// - Control register: SRST bit2, nIEN bit1, bit0 zero
// - Selected and nIEN low: drive INTRQ
// - nIEN high or unselected: INTRQ floats
// - SRST high holds device in reset
// - SRST cleared: device leaves reset
// - SRST resets both chained devices alike
// - Command write starts execution
// - Power commands accepted under two opcodes
// - SMART opcode decoded by features subcode
// - Security opcodes decoded, non-data or out
// - F8h read max; F9h by subcode
// - Overlay opcode B1h decoded by subcode
// - Sample only parameters valid for opcode
// - Device-only commands use only select bit
// - Primary status read acknowledges interrupt
// - Invalid opcode sets aborted-command bit
// - Class 1 commands raise BSY within 400ns
`timescale 1ns/1ps
module atfc_top #(
  parameter bit DEV_NUM = 1'b0 // This device's select value
) (
  input  wire logic       clk_sys_i,    // System clock
  input  wire logic       reset_n_i,    // Async reset, active low
  input  wire logic [4:0] addr_i,       // {cs1,cs0,a2,a1,a0}
  input  wire logic       rd_i,         // Read strobe pulse
  input  wire logic       wr_i,         // Write strobe pulse
  input  wire logic [7:0] wdata_i,      // Write data
  input  wire logic       cmd_done_i,   // Execution finished pulse
  input  wire logic       cmd_error_i,  // Finish with error
  output logic [7:0]      rdata_o,      // Read data, registered
  output logic            rvalid_o,     // Read data valid pulse
  output logic            intrq_o,      // Interrupt level when driven
  output logic            intrq_oe_n_o, // INTRQ enable, low drives
  output logic            dev_reset_o,  // Device held in reset
  output logic            cmd_start_o,  // Command start pulse
  output logic [7:0]      cmd_op_o,     // Accepted opcode
  output logic [2:0]      cmd_proto_o,  // Decoded protocol
  output logic [4:0]      cmd_pvalid_o, // Valid parameter mask
  output logic [7:0]      prm_feat_o,   // Sampled features
  output logic [7:0]      prm_cnt_o,    // Sampled count
  output logic [7:0]      prm_sec_o,    // Sampled start sector
  output logic [15:0]     prm_cyl_o,    // Sampled cylinder
  output logic [7:0]      prm_dh_o      // Sampled device/head
);
  localparam logic [7:0] BYTE0 = 8'h00;

  atfc_pkg::atfc_state_t state_q, state_d;
  logic [7:0]  feat_q, cnt_q, sec_q, cyl_lo_q, cyl_hi_q, dh_q;
  logic [7:0]  feat_d, cnt_d, sec_d, cyl_lo_d, cyl_hi_d, dh_d;
  logic [7:0]  stat_q, stat_d, err_q, err_d;
  logic        irq_q, irq_d;
  logic [7:0]  rdata_d;
  logic        rvalid_d;
  logic        oe_n_d, intrq_d, devrst_d;
  logic        oe_n_q, intrq_q, devrst_q;
  logic        start_d, start_q;
  logic [7:0]  op_d, op_q;
  logic [2:0]  proto_d, proto_q;
  logic [4:0]  pv_d, pv_q;
  logic [7:0]  pf_d, pc_d, ps_d, pcl_d, pch_d, pdh_d;
  logic [7:0]  pf_q, pc_q, ps_q, pcl_q, pch_q, pdh_q;
  logic        srst, nien, ctrl_wr, cmd_wr, selected;
  atfc_pkg::atfc_proto_t dec_proto;
  logic [4:0]  dec_pv;
  logic        dec_devonly;

  assign ctrl_wr  = wr_i && (addr_i == atfc_pkg::ADDR_ALT_CTRL);
  // Control write taken regardless of device select
  assign cmd_wr   = wr_i && (addr_i == atfc_pkg::ADDR_STAT_CMD) && selected && !srst &&
                    !stat_q[atfc_pkg::STAT_BSY_BIT];
  assign selected = (dh_q[atfc_pkg::DH_DRV_BIT] == DEV_NUM);

  atfc_ctrl_reg u_ctrl (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .wr_i      (ctrl_wr),
    .wdata_i   (wdata_i),
    .srst_o    (srst),
    .nien_o    (nien)
  );

  atfc_decode u_dec (
    .opcode_i   (wdata_i),
    .feature_i  (feat_q),
    .proto_o    (dec_proto),
    .pvalid_o   (dec_pv),
    .dev_only_o (dec_devonly)
  );

  // Task-file registers, status, error and pending interrupt
  always_comb begin
    state_d  = state_q;
    feat_d   = feat_q;
    cnt_d    = cnt_q;
    sec_d    = sec_q;
    cyl_lo_d = cyl_lo_q;
    cyl_hi_d = cyl_hi_q;
    dh_d     = dh_q;
    stat_d   = stat_q;
    err_d    = err_q;
    irq_d    = irq_q;
    start_d  = 1'b0;
    op_d     = op_q;
    proto_d  = proto_q;
    pv_d     = pv_q;
    pf_d     = pf_q;
    pc_d     = pc_q;
    ps_d     = ps_q;
    pcl_d    = pcl_q;
    pch_d    = pch_q;
    pdh_d    = pdh_q;
    if (wr_i && !stat_q[atfc_pkg::STAT_BSY_BIT]) begin
      case (addr_i)
        atfc_pkg::ADDR_ERR_FEAT: feat_d   = wdata_i;
        atfc_pkg::ADDR_COUNT:    cnt_d    = wdata_i;
        atfc_pkg::ADDR_SECTOR:   sec_d    = wdata_i;
        atfc_pkg::ADDR_CYL_LO:   cyl_lo_d = wdata_i;
        atfc_pkg::ADDR_CYL_HI:   cyl_hi_d = wdata_i;
        atfc_pkg::ADDR_DRV_HEAD: dh_d     = wdata_i;
        default:                 feat_d   = feat_q;
      endcase
    end
    // Primary status read acknowledges; alternate does not
    if (rd_i && (addr_i == atfc_pkg::ADDR_STAT_CMD) && selected) begin
      irq_d = 1'b0;
    end
    case (state_q)
      atfc_pkg::ATFC_ST_RESET: begin
        stat_d = atfc_pkg::STAT_RESET;
        err_d  = atfc_pkg::ERR_RESET;
        irq_d  = 1'b0;
        if (!srst) begin
          state_d = atfc_pkg::ATFC_ST_IDLE;
          stat_d  = atfc_pkg::STAT_IDLE;
        end
      end
      atfc_pkg::ATFC_ST_IDLE: begin
        if (cmd_wr) begin
          // Busy raised on the write edge itself
          stat_d = atfc_pkg::STAT_RESET;
          irq_d  = 1'b0;
          if (dec_proto == atfc_pkg::ATFC_PROTO_NONE) begin
            err_d   = 8'h01 << atfc_pkg::ERR_ABRT_BIT;
            state_d = atfc_pkg::ATFC_ST_EXEC;
          end else begin
            err_d   = BYTE0;
            start_d = 1'b1;
            state_d = atfc_pkg::ATFC_ST_EXEC;
            op_d    = wdata_i;
            proto_d = dec_proto;
            pv_d    = dec_pv;
            // Sample only valid registers, others zero; device/head keeps the select bit when not valid
            pf_d  = dec_pv[atfc_pkg::PV_FEAT] ? feat_q : BYTE0;
            pc_d  = dec_pv[atfc_pkg::PV_CNT]  ? cnt_q : BYTE0;
            ps_d  = dec_pv[atfc_pkg::PV_SEC]  ? sec_q : BYTE0;
            pcl_d = dec_pv[atfc_pkg::PV_CYL]  ? cyl_lo_q : BYTE0;
            pch_d = dec_pv[atfc_pkg::PV_CYL]  ? cyl_hi_q : BYTE0;
            pdh_d = dec_devonly ? (dh_q & (8'h01 << atfc_pkg::DH_DRV_BIT)) : dh_q;
          end
        end
      end
      atfc_pkg::ATFC_ST_EXEC: begin
        // Invalid opcode completes at once with error
        if (cmd_done_i || (err_q[atfc_pkg::ERR_ABRT_BIT] && !start_q)) begin
          state_d = atfc_pkg::ATFC_ST_IDLE;
          stat_d  = atfc_pkg::STAT_IDLE;
          stat_d[atfc_pkg::STAT_ERR_BIT] = (cmd_error_i && cmd_done_i) || err_q[atfc_pkg::ERR_ABRT_BIT];
          if (cmd_error_i && cmd_done_i) begin
            err_d = 8'h01 << atfc_pkg::ERR_ABRT_BIT;
          end
          irq_d = 1'b1;
        end
      end
      default: state_d = atfc_pkg::ATFC_ST_RESET;
    endcase
    if (srst) begin
      state_d = atfc_pkg::ATFC_ST_RESET;
      stat_d  = atfc_pkg::STAT_RESET;
      irq_d   = 1'b0;
      start_d = 1'b0;
    end
  end

  // Read data and INTRQ pin outputs
  always_comb begin
    rvalid_d = rd_i;
    case (addr_i)
      atfc_pkg::ADDR_ERR_FEAT: rdata_d = err_q;
      atfc_pkg::ADDR_COUNT:    rdata_d = cnt_q;
      atfc_pkg::ADDR_SECTOR:   rdata_d = sec_q;
      atfc_pkg::ADDR_CYL_LO:   rdata_d = cyl_lo_q;
      atfc_pkg::ADDR_CYL_HI:   rdata_d = cyl_hi_q;
      atfc_pkg::ADDR_DRV_HEAD: rdata_d = dh_q;
      atfc_pkg::ADDR_STAT_CMD: rdata_d = stat_q;
      atfc_pkg::ADDR_ALT_CTRL: rdata_d = stat_q;
      default:                 rdata_d = BYTE0;
    endcase
    if (!rd_i) begin
      rdata_d = rdata_o;
    end
    oe_n_d   = !(selected && !nien);
    intrq_d  = irq_d && selected && !nien;
    devrst_d = (state_d == atfc_pkg::ATFC_ST_RESET);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q  <= atfc_pkg::ATFC_ST_RESET;
      {feat_q, cnt_q, sec_q, cyl_lo_q, cyl_hi_q, dh_q} <= '0;
      stat_q   <= atfc_pkg::STAT_RESET;
      err_q    <= atfc_pkg::ERR_RESET;
      irq_q    <= 1'b0;
      start_q  <= 1'b0;
      op_q     <= 8'h00;
      proto_q  <= atfc_pkg::ATFC_PROTO_NONE;
      pv_q     <= 5'h00;
      {pf_q, pc_q, ps_q, pcl_q, pch_q, pdh_q} <= '0;
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
      oe_n_q   <= 1'b1;
      intrq_q  <= 1'b0;
      devrst_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      feat_q   <= feat_d;
      cnt_q    <= cnt_d;
      sec_q    <= sec_d;
      cyl_lo_q <= cyl_lo_d;
      cyl_hi_q <= cyl_hi_d;
      dh_q     <= dh_d;
      stat_q   <= stat_d;
      err_q    <= err_d;
      irq_q    <= irq_d;
      start_q  <= start_d;
      op_q     <= op_d;
      proto_q  <= proto_d;
      pv_q     <= pv_d;
      pf_q     <= pf_d;
      pc_q     <= pc_d;
      ps_q     <= ps_d;
      pcl_q    <= pcl_d;
      pch_q    <= pch_d;
      pdh_q    <= pdh_d;
      rdata_o  <= rdata_d;
      rvalid_o <= rvalid_d;
      oe_n_q   <= oe_n_d;
      intrq_q  <= intrq_d;
      devrst_q <= devrst_d;
    end
  end

  assign intrq_o      = intrq_q;
  assign intrq_oe_n_o = oe_n_q;
  assign dev_reset_o  = devrst_q;
  assign cmd_start_o  = start_q;
  assign cmd_op_o     = op_q;
  assign cmd_proto_o  = proto_q;
  assign cmd_pvalid_o = pv_q;
  assign prm_feat_o   = pf_q;
  assign prm_cnt_o    = pc_q;
  assign prm_sec_o    = ps_q;
  assign prm_cyl_o    = {pch_q, pcl_q};
  assign prm_dh_o     = pdh_q;

  sequence s_cmd_write;
    cmd_wr && state_q == atfc_pkg::ATFC_ST_IDLE && !srst;
  endsequence

  AST_ALT_MIRROR: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_i && addr_i == atfc_pkg::ADDR_ALT_CTRL |=> rdata_o == $past(stat_q))
    else $error("alternate status differs from status");
  AST_ALT_KEEPS_IRQ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_i && addr_i == atfc_pkg::ADDR_ALT_CTRL && irq_q && !srst && state_q == atfc_pkg::ATFC_ST_IDLE
    && !wr_i |=> irq_q)
    else $error("alternate status read cleared interrupt");
  AST_INTRQ_DRIVE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    selected && !nien |=> !intrq_oe_n_o)
    else $error("INTRQ not driven while enabled");
  AST_INTRQ_FLOAT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    nien || !selected |=> intrq_oe_n_o && !intrq_o)
    else $error("INTRQ driven while disabled");
  AST_SRST_HOLD: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    srst |=> dev_reset_o && stat_q[atfc_pkg::STAT_BSY_BIT])
    else $error("device not in reset during SRST");
  AST_SRST_EXIT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == atfc_pkg::ATFC_ST_RESET && !srst |=> !dev_reset_o)
    else $error("device did not leave reset");
  AST_BSY_TIME: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_cmd_write |-> ##[1:2] stat_q[atfc_pkg::STAT_BSY_BIT])
    else $error("BSY not raised in time");
  AST_ABORT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_cmd_write ##0 dec_proto == atfc_pkg::ATFC_PROTO_NONE |=> err_q[atfc_pkg::ERR_ABRT_BIT] && !cmd_start_o)
    else $error("invalid opcode not aborted");
  AST_ACK: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    rd_i && addr_i == atfc_pkg::ADDR_STAT_CMD && selected && state_q != atfc_pkg::ATFC_ST_EXEC |=> !irq_q)
    else $error("status read did not acknowledge");
endmodule : atfc_top

/* File: inc/atfc_pkg.sv */
// Package of constants and types for the task-file command control block
package atfc_pkg;

  // Task-file register selects {cs1, cs0, a2, a1, a0}; cs bits set to 1 when asserted
  localparam logic [4:0] ADDR_ERR_FEAT  = 5'h09;
  localparam logic [4:0] ADDR_COUNT     = 5'h0a;
  localparam logic [4:0] ADDR_SECTOR    = 5'h0b;
  localparam logic [4:0] ADDR_CYL_LO    = 5'h0c;
  localparam logic [4:0] ADDR_CYL_HI    = 5'h0d;
  localparam logic [4:0] ADDR_DRV_HEAD  = 5'h0e;
  localparam logic [4:0] ADDR_STAT_CMD  = 5'h0f;
  localparam logic [4:0] ADDR_ALT_CTRL  = 5'h16;

  // Device control bits
  localparam int unsigned CTRL_SRST_BIT = 2;
  localparam int unsigned CTRL_NIEN_BIT = 1;
  localparam int unsigned CTRL_ZERO_BIT = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Status bits
  localparam int unsigned STAT_BSY_BIT  = 7;
  localparam int unsigned STAT_DRDY_BIT = 6;
  localparam int unsigned STAT_DRQ_BIT  = 3;
  localparam int unsigned STAT_ERR_BIT  = 0;
  localparam logic [7:0]  STAT_RESET    = 8'h80;
  localparam logic [7:0]  STAT_IDLE     = 8'h50;

  // Error register
  localparam int unsigned ERR_ABRT_BIT  = 2;
  localparam logic [7:0]  ERR_RESET     = 8'h01;

  // Device/head select bit
  localparam int unsigned DH_DRV_BIT    = 4;

  // Busy deadline after a command write
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned BSY_MAX_NS    = 400;
  localparam int unsigned BSY_MAX_CYC   = (BSY_MAX_NS * 1000) / CLK_PERIOD_PS;

  // Parameter-valid mask bits
  localparam int unsigned PV_FEAT = 4;
  localparam int unsigned PV_CNT  = 3;
  localparam int unsigned PV_SEC  = 2;
  localparam int unsigned PV_CYL  = 1;
  localparam int unsigned PV_DH   = 0;

  typedef enum logic [2:0] {
    ATFC_PROTO_NONE = 3'b000,
    ATFC_PROTO_PIN  = 3'b001,
    ATFC_PROTO_POUT = 3'b010,
    ATFC_PROTO_DMA  = 3'b011,
    ATFC_PROTO_ND   = 3'b100
  } atfc_proto_t;

  typedef enum logic [1:0] {
    ATFC_ST_RESET = 2'b00,
    ATFC_ST_IDLE  = 2'b01,
    ATFC_ST_EXEC  = 2'b10
  } atfc_state_t;

endpackage : atfc_pkg

/* File: design/atfc_decode.sv */
// Combinational opcode decoder: protocol and valid parameter registers
`timescale 1ns/1ps
module atfc_decode (
  input  wire logic [7:0]          opcode_i,  // Command opcode
  input  wire logic [7:0]          feature_i, // Features subcode
  output atfc_pkg::atfc_proto_t    proto_o,   // Decoded protocol
  output logic [4:0]               pvalid_o,  // Valid parameter mask
  output logic                     dev_only_o // Only device select used
);
  // V on count, sector, cylinder, device/head
  localparam logic [4:0] M_CSCD = 5'b01111;
  localparam logic [4:0] M_D    = 5'b00000;

  always_comb begin
    proto_o    = atfc_pkg::ATFC_PROTO_NONE;
    pvalid_o   = M_D;
    dev_only_o = 1'b1;
    case (opcode_i) inside
      8'h20, 8'h21, 8'h22, 8'h23, 8'hc4: begin
        proto_o = atfc_pkg::ATFC_PROTO_PIN;
        pvalid_o = M_CSCD;
      end
      8'he4, 8'hec: proto_o = atfc_pkg::ATFC_PROTO_PIN;
      8'hc8, 8'hc9, 8'hca, 8'hcb: begin
        proto_o = atfc_pkg::ATFC_PROTO_DMA;
        pvalid_o = M_CSCD;
      end
      8'h40, 8'h41: begin
        proto_o = atfc_pkg::ATFC_PROTO_ND;
        pvalid_o = M_CSCD;
      end
      8'h30, 8'h31, 8'h32, 8'h33, 8'hc5: begin
        proto_o = atfc_pkg::ATFC_PROTO_POUT;
        pvalid_o = M_CSCD;
      end
      8'he8: proto_o = atfc_pkg::ATFC_PROTO_POUT;
      8'h50: begin
        proto_o = atfc_pkg::ATFC_PROTO_POUT;
        pvalid_o = 5'b01011;
      end
      [8'h10:8'h1f], 8'he7, 8'h90: proto_o = atfc_pkg::ATFC_PROTO_ND;
      [8'h70:8'h7f]: begin
        proto_o = atfc_pkg::ATFC_PROTO_ND;
        pvalid_o = 5'b00111;
      end
      8'h91: begin
        proto_o = atfc_pkg::ATFC_PROTO_ND;
        pvalid_o = 5'b01001;
      end
      8'hef: begin
        proto_o = atfc_pkg::ATFC_PROTO_ND;
        pvalid_o = 5'b10000;
      end
      8'hc6, 8'h98, 8'he5, 8'h97, 8'he3, 8'h96, 8'he2: begin
        proto_o = atfc_pkg::ATFC_PROTO_ND;
        pvalid_o = 5'b01000;
      end
      8'h95, 8'he1, 8'h99, 8'he6, 8'h94, 8'he0: proto_o = atfc_pkg::ATFC_PROTO_ND;
      8'hb0: begin
        case (feature_i)
          8'hd2, 8'hdb: begin
            proto_o = atfc_pkg::ATFC_PROTO_ND;
            pvalid_o = 5'b11010;
          end
          8'hd3, 8'hd8, 8'hd9, 8'hda, 8'hd4: begin
            proto_o = atfc_pkg::ATFC_PROTO_ND;
            pvalid_o = 5'b10010;
          end
          8'hd5: begin
            proto_o = atfc_pkg::ATFC_PROTO_PIN;
            pvalid_o = 5'b11110;
          end
          8'hd6: begin
            proto_o = atfc_pkg::ATFC_PROTO_POUT;
            pvalid_o = 5'b11110;
          end
          default: proto_o = atfc_pkg::ATFC_PROTO_NONE;
        endcase
      end
      8'hf3, 8'hf5, 8'hf8: proto_o = atfc_pkg::ATFC_PROTO_ND;
      8'hf1, 8'hf2, 8'hf4, 8'hf6: proto_o = atfc_pkg::ATFC_PROTO_POUT;
      8'hf9: begin
        pvalid_o = 5'b10000;
        case (feature_i)
          8'h00: begin
            proto_o = atfc_pkg::ATFC_PROTO_ND;
            pvalid_o = 5'b11110;
          end
          8'h02, 8'h04: proto_o = atfc_pkg::ATFC_PROTO_ND;
          8'h01, 8'h03: proto_o = atfc_pkg::ATFC_PROTO_POUT;
          default:      proto_o = atfc_pkg::ATFC_PROTO_NONE;
        endcase
      end
      8'hb1: begin
        pvalid_o = 5'b10000;
        case (feature_i)
          8'hc0, 8'hc1: proto_o = atfc_pkg::ATFC_PROTO_ND;
          8'hc2:        proto_o = atfc_pkg::ATFC_PROTO_PIN;
          8'hc3:        proto_o = atfc_pkg::ATFC_PROTO_POUT;
          default:      proto_o = atfc_pkg::ATFC_PROTO_NONE;
        endcase
      end
      default: proto_o = atfc_pkg::ATFC_PROTO_NONE;
    endcase
    // Device-only when device/head not fully valid
    dev_only_o = ~pvalid_o[atfc_pkg::PV_DH];
  end
endmodule : atfc_decode

/* File: design/atfc_ctrl_reg.sv */
// Device control register: soft reset and interrupt-disable bits
`timescale 1ns/1ps
module atfc_ctrl_reg (
  input  wire logic       clk_sys_i, // System clock
  input  wire logic       reset_n_i, // Async reset, active low
  input  wire logic       wr_i,      // Write strobe for control location
  input  wire logic [7:0] wdata_i,   // Written byte
  output logic            srst_o,    // Software reset level
  output logic            nien_o     // Interrupt disable level
);
  logic srst_q, srst_d;
  logic nien_q, nien_d;

  always_comb begin
    srst_d = srst_q;
    nien_d = nien_q;
    if (wr_i) begin
      // Other bits are ignored
      srst_d = wdata_i[atfc_pkg::CTRL_SRST_BIT];
      nien_d = wdata_i[atfc_pkg::CTRL_NIEN_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      srst_q <= atfc_pkg::CTRL_RESET[atfc_pkg::CTRL_SRST_BIT];
      nien_q <= atfc_pkg::CTRL_RESET[atfc_pkg::CTRL_NIEN_BIT];
    end else begin
      srst_q <= srst_d;
      nien_q <= nien_d;
    end
  end

  assign srst_o = srst_q;
  assign nien_o = nien_q;
endmodule : atfc_ctrl_reg

/* File: verif/atfc_host_model.sv */
// Host adapter model driving the task-file register bus
`timescale 1ns/1ps
module atfc_host_model (
  input  wire logic       clk_sys_i, // System clock
  input  wire logic [7:0] rdata_i,   // Read data from device
  input  wire logic       rvalid_i,  // Read data valid
  output logic [4:0]      addr_o,    // Register select
  output logic            rd_o,      // Read strobe
  output logic            wr_o,      // Write strobe
  output logic [7:0]      wdata_o    // Write data
);
  initial begin
    addr_o  = 5'h00;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_sys_i);
    wr_o    = 1'b0;
    wdata_o = ~d; // Released bus shows no stale data
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_sys_i);
    rd_o   = 1'b0;
    d      = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask : rd_reg

  // Parameters first, opcode last
  task automatic issue(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] dh);
    wr_reg(atfc_pkg::ADDR_ERR_FEAT, ft);
    wr_reg(atfc_pkg::ADDR_COUNT, 8'h11);
    wr_reg(atfc_pkg::ADDR_SECTOR, 8'h22);
    wr_reg(atfc_pkg::ADDR_CYL_LO, 8'h33);
    wr_reg(atfc_pkg::ADDR_CYL_HI, 8'h44);
    wr_reg(atfc_pkg::ADDR_DRV_HEAD, dh);
    wr_reg(atfc_pkg::ADDR_STAT_CMD, op);
  endtask : issue
endmodule : atfc_host_model

/* File: verif/testbench.sv */
// Self-checking bench for the task-file command control block
`timescale 1ns/1ps
module testbench;
  logic        clk_sys_i;
  logic        reset_n_i;
  logic        cmd_done;
  logic        cmd_err;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        intrq;
  logic        oe_n;
  logic        dev_reset;
  logic        start;
  logic [7:0]  op;
  logic [2:0]  proto;
  logic [4:0]  pvalid;
  logic [7:0]  pf;
  logic [7:0]  pc;
  logic [7:0]  ps;
  logic [15:0] pcy;
  logic [7:0]  pd;
  int          fail_count;
  int          total_checks;
  int          cyc;
  // {opcode, subcode, protocol, valid mask (ff: skip), flags: bit1 subcode, bit0 device-only}
  logic [31:0] rows [$] = {
    32'h2000_10f0, 32'h2100_10f0, 32'h2200_10f0, 32'h2300_10f0, 32'hc400_10f0, 32'he400_1001,
    32'hc800_30f0, 32'hc900_30f0, 32'hca00_30f0, 32'hcb00_30f0, 32'h4000_40f0, 32'h4100_40f0,
    32'h3000_20f0, 32'h3100_20f0, 32'h3200_20f0, 32'h3300_20f0, 32'hc500_20f0, 32'he800_2001,
    32'h5000_20b0, 32'he700_4001, 32'h1500_4001, 32'h7c00_4070, 32'h9000_4001, 32'h9100_4090,
    32'hec00_1001, 32'hef00_4101, 32'hc600_4081, 32'h9800_4081, 32'he500_4081, 32'h9700_4081,
    32'he300_4081, 32'h9500_4001, 32'he100_4001, 32'h9900_4001, 32'he600_4001, 32'h9600_4081,
    32'he200_4081, 32'h9400_4001, 32'he000_4001, 32'hb0d2_4ff3, 32'hb0d3_4ff3, 32'hb0d8_4ff3,
    32'hb0d9_4ff3, 32'hb0da_4ff3, 32'hb0db_4ff3, 32'hb0d4_4ff3, 32'hb0d5_1ff3, 32'hb0d6_2ff3,
    32'hf100_2001, 32'hf200_2001, 32'hf400_2001, 32'hf600_2001, 32'hf300_4001, 32'hf500_4001,
    32'hf800_4001, 32'hf900_4ff3, 32'hf901_2ff3, 32'hf902_4ff3, 32'hf903_2ff3, 32'hf904_4ff3,
    32'hb1c0_4ff3, 32'hb1c1_4ff3, 32'hb1c2_1ff3, 32'hb1c3_2ff3};

  atfc_top #(.DEV_NUM(1'b1)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata),
    .cmd_done_i(cmd_done), .cmd_error_i(cmd_err), .rdata_o(rdata), .rvalid_o(rvalid), .intrq_o(intrq),
    .intrq_oe_n_o(oe_n), .dev_reset_o(dev_reset), .cmd_start_o(start), .cmd_op_o(op), .cmd_proto_o(proto),
    .cmd_pvalid_o(pvalid), .prm_feat_o(pf), .prm_cnt_o(pc), .prm_sec_o(ps), .prm_cyl_o(pcy), .prm_dh_o(pd));

  atfc_host_model u_host (
    .clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic finish_cmd();
    @(negedge clk_sys_i);
    cmd_done = 1'b1;
    @(negedge clk_sys_i);
    cmd_done = 1'b0;
    @(negedge clk_sys_i);
  endtask : finish_cmd

  task automatic t_reset();
    logic [7:0] d;
    u_host.rd_reg(atfc_pkg::ADDR_STAT_CMD, d);
    chk(16'(d), 16'(atfc_pkg::STAT_IDLE), "status after reset");
    u_host.rd_reg(atfc_pkg::ADDR_ALT_CTRL, d);
    chk(16'(d), 16'(atfc_pkg::STAT_IDLE), "alt status after reset");
    chk(16'(oe_n), 16'h1, "irq float while unselected");
    $display("test reset done");
  endtask : t_reset

  task automatic t_irq();
    logic [7:0] d;
    u_host.issue(8'h20, 8'h5a, 8'hff);
    u_host.rd_reg(atfc_pkg::ADDR_ALT_CTRL, d);
    chk(16'(d[7]), 16'h1, "busy soon after command");
    finish_cmd();
    chk(16'({intrq, oe_n}), 16'h2, "irq driven");
    u_host.rd_reg(atfc_pkg::ADDR_ALT_CTRL, d);
    @(negedge clk_sys_i);
    chk(16'(intrq), 16'h1, "alt read keeps irq");
    chk(16'(d), 16'(atfc_pkg::STAT_IDLE), "alt status");
    u_host.rd_reg(atfc_pkg::ADDR_STAT_CMD, d);
    @(negedge clk_sys_i);
    chk(16'(intrq), 16'h0, "status read clears irq");
    $display("test irq done");
  endtask : t_irq

  task automatic t_decode();
    logic [31:0] r;
    logic [4:0]  pv;
    logic [7:0]  d;
    foreach (rows[i]) begin
      r  = rows[i];
      pv = r[8:4];
      u_host.issue(r[31:24], r[1] ? r[23:16] : 8'h5a, 8'hff);
      chk(16'(start), 16'h1, "start");
      chk(16'(op), 16'(r[31:24]), "opcode");
      chk(16'(proto), 16'(r[14:12]), "protocol");
      if (r[11:4] != 8'hff) begin
        chk(16'(pvalid), 16'(pv), "valid mask");
        chk(16'(pf), pv[4] ? 16'h5a : 16'h0, "features");
        chk(16'(pc), pv[3] ? 16'h11 : 16'h0, "count");
        chk(16'(ps), pv[2] ? 16'h22 : 16'h0, "sector");
        chk(pcy, pv[1] ? 16'h4433 : 16'h0, "cylinder");
      end
      chk(16'(pd), r[0] ? 16'h10 : 16'hff, "device head");
      finish_cmd();
      u_host.rd_reg(atfc_pkg::ADDR_STAT_CMD, d);
      chk(16'(d), 16'(atfc_pkg::STAT_IDLE), "status after done");
    end
    $display("test decode done");
  endtask : t_decode

  task automatic t_invalid();
    logic [7:0] d;
    u_host.issue(8'hff, 8'h5a, 8'hff);
    chk(16'(start), 16'h0, "no start on bad opcode");
    u_host.rd_reg(atfc_pkg::ADDR_STAT_CMD, d);
    chk(16'(d), 16'h51, "error status");
    u_host.rd_reg(atfc_pkg::ADDR_ERR_FEAT, d);
    chk(16'(d), 16'h04, "aborted bit");
    // Executor reports failure on a valid command
    u_host.issue(8'h20, 8'h5a, 8'hff);
    cmd_err = 1'b1;
    finish_cmd();
    cmd_err = 1'b0;
    u_host.rd_reg(atfc_pkg::ADDR_STAT_CMD, d);
    chk(16'(d), 16'h51, "executor error status");
    u_host.rd_reg(atfc_pkg::ADDR_ERR_FEAT, d);
    chk(16'(d), 16'h04, "executor error code");
    $display("test invalid done");
  endtask : t_invalid

  task automatic t_ctrl();
    logic [7:0] d;
    u_host.wr_reg(atfc_pkg::ADDR_ALT_CTRL, 8'h02);
    @(negedge clk_sys_i);
    chk(16'(oe_n), 16'h1, "irq disabled floats");
    u_host.wr_reg(atfc_pkg::ADDR_ALT_CTRL, 8'hf9);
    @(negedge clk_sys_i);
    chk(16'({dev_reset, oe_n}), 16'h0, "other bits ignored");
    u_host.wr_reg(atfc_pkg::ADDR_DRV_HEAD, 8'hef);
    u_host.wr_reg(atfc_pkg::ADDR_ALT_CTRL, 8'h04);
    @(negedge clk_sys_i);
    chk(16'({dev_reset, oe_n}), 16'h3, "reset while unselected");
    u_host.rd_reg(atfc_pkg::ADDR_ALT_CTRL, d);
    repeat (8) @(negedge clk_sys_i);
    chk(16'(dev_reset), 16'h1, "held in reset");
    chk(16'(d), 16'(atfc_pkg::STAT_RESET), "busy in reset");
    u_host.wr_reg(atfc_pkg::ADDR_ALT_CTRL, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    u_host.rd_reg(atfc_pkg::ADDR_STAT_CMD, d);
    chk(16'({dev_reset, d}), 16'(atfc_pkg::STAT_IDLE), "leaves reset");
    $display("test control done");
  endtask : t_ctrl

  initial begin
    reset_n_i    = 1'b0;
    cmd_done     = 1'b0;
    cmd_err      = 1'b0;
    fail_count   = 0;
    total_checks = 0;
    cyc          = 0;
    repeat (20) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    t_reset();
    t_irq();
    t_decode();
    t_invalid();
    t_ctrl();
    print_verdict();
  end
endmodule : testbench
